// ---- hw/adc_ctrl.sv ----
// Overview of operation
// RULE1: Select low write loads control word
// RULE2: Select low read returns control word
// RULE3: Control word: mode, gain, channel, flags, filter
// RULE4: Only full 24-bit writes update control
// RULE5: Clocks after the 24th are ignored
// RULE6: Host reads all 24 control bits
// RULE7: Mode zero normal, data reads, reset value
// RULE8: Mode one self calibrates, then clears
// RULE9: Mode two system zero-scale step
// RULE10: Mode three system full-scale step
// RULE11: Mode four system offset calibration
// RULE12: Mode five background, word rate sixth
// RULE13: Mode six accesses zero-scale coefficient
// RULE14: Mode seven accesses full-scale coefficient
// RULE15: Coefficient transfers always 24 bits
// RULE16: Coefficient stored only after full write
// RULE17: Host data valid at rising clock
// RULE18: Host lowers write frame before data
// RULE19: Ready low on result, high after read
// RULE20: Width bit: clear 16, set 24
// RULE21: Calibration starts once per full write
// RULE22: Calibration holds ready high, no results
`timescale 1ns/1ps
module adc_ctrl
    import adc_ctrl_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire logic        sclk_i,
    input  wire logic        write_frame_n_i,
    input  wire logic        read_frame_n_i,
    input  wire logic        register_select_pin_i,
    input  wire logic        serial_io_line_i,
    output logic             serial_io_line_o,
    output logic             serial_io_line_oe_n_o,
    output logic             result_ready_n_o,
    input  wire logic        conv_valid_i,
    input  wire logic [23:0] conv_data_i,
    input  wire logic        cal_done_i,
    input  wire logic [23:0] cal_zero_i,
    input  wire logic [23:0] cal_full_i,
    output logic             cal_start_o,
    output logic      [2:0]  cal_mode_o,
    output logic      [2:0]  gain_o,
    output logic      [1:0]  channel_o,
    output logic             excitation_current_enable_o,
    output logic             burnout_current_enable_o,
    output logic             unipolar_o,
    output logic      [11:0] notch_code_o,
    output logic             background_cal_o
);

    link_st_t lk_q;       // Serial clock domain state
    link_st_t lk_d;       // Next serial clock domain state
    main_st_t st_q;       // Master clock domain state
    main_st_t st_d;       // Next master clock domain state

    logic [2:0]  mode;    // Current operating mode field
    logic [1:0]  chan;    // Current channel field
    logic        wev;     // One written bit arrived
    logic        rev;     // One read bit was clocked
    logic        rfall;   // Read frame just opened
    logic        commit;  // Full word just received
    logic [23:0] rword;   // Word chosen for a read
    logic [4:0]  rlen;    // Its length in bits
    logic        is_data; // Read targets the data word
    logic        mz_we;   // Zero coefficient write
    logic        mf_we;   // Full coefficient write
    logic [23:0] mz_wd;   // Zero coefficient data
    logic [23:0] mf_wd;   // Full coefficient data
    logic [23:0] cz_rd;   // Stored zero coefficient
    logic [23:0] cf_rd;   // Stored full coefficient

    // True for the four one-shot calibration codes
    function automatic logic is_cal(input logic [2:0] m);
        is_cal = (m == `MODE_SELF_CAL) || (m == `MODE_SYS_ZERO) ||
                 (m == `MODE_SYS_FULL) || (m == `MODE_SYS_OFS);
    endfunction : is_cal

    assign mode = st_q.ctrl[`MODE_HI:`MODE_LO];
    assign chan = st_q.ctrl[`CHAN_HI:`CHAN_LO];

    // Link side: only shifts bits and toggles per clock edge.
    // Counting lives in the master domain, so nothing here must be
    // cleared at frame end while the serial clock may be stopped.
    always_comb
    begin
        lk_d        = lk_q;
        lk_d.rst_s1 = reset_i;
        lk_d.rst_s2 = lk_q.rst_s1;
        if (lk_q.rst_s2)
        begin
            lk_d.sh = '0;
            lk_d.wt = 1'b0;
            lk_d.rt = 1'b0;
        end
        else
        begin
            // Data sampled on rising edge while frame is low [RULE17]
            if (!write_frame_n_i)
            begin
                lk_d.sh = {lk_q.sh[22:0], serial_io_line_i};
                lk_d.wt = ~lk_q.wt;
            end
            // Each read edge asks the master side for the next bit
            if (!read_frame_n_i)
            begin
                lk_d.rt = ~lk_q.rt;
            end
        end
    end

    // Serial clock domain register
    always_ff @(posedge sclk_i)
    begin
        lk_q <= lk_d;
    end

    // Coefficient store, indexed by channel code
    coef_mem u_coef_mem (
        .mclk_i         (mclk_i),
        .reset_i        (reset_i),
        .wr_addr_i      (chan),
        .wr_zero_i      (mz_we),
        .wr_full_i      (mf_we),
        .wr_zero_data_i (mz_wd),
        .wr_full_data_i (mf_wd),
        .rd_addr_i      (chan),
        .rd_zero_o      (cz_rd),
        .rd_full_o      (cf_rd)
    );

    // Choice of word and length for a read frame
    always_comb
    begin
        rword   = st_q.ctrl;
        rlen    = `WORD_BITS;
        is_data = 1'b0;
        if (!st_q.rs_s2)
        begin
            rword = st_q.ctrl;  // Full length [RULE2] [RULE6]
        end
        else if (mode == `MODE_ZS_COEF)
        begin
            rword = cz_rd;  // [RULE13] [RULE15]
        end
        else if (mode == `MODE_FS_COEF)
        begin
            rword = cf_rd;  // [RULE14] [RULE15]
        end
        else
        begin
            // Data word; short form sends the upper bits [RULE7]
            is_data = 1'b1;
            if (!st_q.ctrl[`WL_BIT])
            begin
                rlen  = `SHORT_BITS;  // [RULE20]
                rword = {st_q.dreg[23:8], 8'h00};
            end
            else
            begin
                rword = st_q.dreg;  // [RULE20]
            end
        end
    end

    // Master domain: sync, framing, mode sequencing, ready
    always_comb
    begin
        st_d       = st_q;
        mz_we      = 1'b0;
        mf_we      = 1'b0;
        mz_wd      = lk_q.sh;
        mf_wd      = lk_q.sh;
        commit     = 1'b0;

        // Two-stage synchronisers; third stage only for edges
        st_d.wf_s1 = write_frame_n_i;
        st_d.wf_s2 = st_q.wf_s1;
        st_d.rf_s1 = read_frame_n_i;
        st_d.rf_s2 = st_q.rf_s1;
        st_d.rf_s3 = st_q.rf_s2;
        st_d.rs_s1 = register_select_pin_i;
        st_d.rs_s2 = st_q.rs_s1;
        st_d.wt_s1 = lk_q.wt;
        st_d.wt_s2 = st_q.wt_s1;
        st_d.wt_s3 = st_q.wt_s2;
        st_d.rt_s1 = lk_q.rt;
        st_d.rt_s2 = st_q.rt_s1;
        st_d.rt_s3 = st_q.rt_s2;
        wev        = st_q.wt_s2 ^ st_q.wt_s3;
        rev        = st_q.rt_s2 ^ st_q.rt_s3;
        rfall      = st_q.rf_s3 & ~st_q.rf_s2;
        st_d.cal_start = 1'b0;

        // Write framing: count bits, stop at the full word
        if (st_q.wf_s2)
        begin
            // Frame closed; a short word is simply dropped [RULE4]
            st_d.wcnt = '0;
        end
        else if (wev && (st_q.wcnt != `WORD_BITS))  // [RULE5]
        begin
            st_d.wcnt = st_q.wcnt + 5'd1;
            commit    = (st_q.wcnt == (`WORD_BITS - 5'd1));  // [RULE4]
        end

        // Calibration result: store coefficients; one-shot steps also report and go normal
        if (cal_done_i && (st_q.busy || (mode == `MODE_BG_CAL)))
        begin
            mz_wd = cal_zero_i;
            mf_wd = cal_full_i;
            // Steps two and three write one half only [RULE8] [RULE11]
            mz_we = (mode != `MODE_SYS_FULL);  // [RULE9] [RULE12]
            mf_we = (mode != `MODE_SYS_ZERO);  // [RULE10] [RULE12]
            if (st_q.busy)
            begin
                // One-shot steps end back in normal mode [RULE8] [RULE9]
                st_d.ctrl[`MODE_HI:`MODE_LO] = `MODE_NORMAL;  // [RULE10]
                st_d.busy  = 1'b0;  // [RULE11]
                st_d.rdy_n = 1'b0;  // [RULE19]
            end
        end

        // Full word taken; word stays put for a whole serial period
        if (commit)
        begin
            if (!st_q.rs_s2)
            begin
                st_d.ctrl  = lk_q.sh;  // [RULE1] [RULE3]
                // Start exactly once per accepted calibration word [RULE21]
                st_d.busy      = is_cal(lk_q.sh[`MODE_HI:`MODE_LO]);
                st_d.cal_start = is_cal(lk_q.sh[`MODE_HI:`MODE_LO]);
                st_d.bgcnt     = '0;
                if (is_cal(lk_q.sh[`MODE_HI:`MODE_LO]))
                begin
                    st_d.rdy_n = 1'b1;  // [RULE22]
                end
            end
            else if (mode == `MODE_ZS_COEF)
            begin
                mz_we = 1'b1;  // [RULE13] [RULE16]
                mz_wd = lk_q.sh;
            end
            else if (mode == `MODE_FS_COEF)
            begin
                mf_we = 1'b1;  // [RULE14] [RULE16]
                mf_wd = lk_q.sh;
            end
        end

        // Read framing: first bit at frame open, next per edge
        if (st_q.rf_s2)
        begin
            st_d.oe_n = 1'b1;
            st_d.rcnt = '0;
            st_d.sdo  = 1'b0;
        end
        else if (rfall)
        begin
            st_d.tx    = {rword[22:0], 1'b0};
            st_d.sdo   = rword[23];
            st_d.rlen  = rlen;
            st_d.rdata = is_data;
            st_d.rcnt  = '0;
            // Data word only goes out while a result is waiting
            st_d.oe_n  = is_data & st_q.rdy_n;
        end
        else if (rev && (st_q.rcnt != st_q.rlen))
        begin
            st_d.rcnt = st_q.rcnt + 5'd1;
            st_d.sdo  = st_q.tx[23];
            st_d.tx   = {st_q.tx[22:0], 1'b0};
            if (st_q.rdata && !st_q.oe_n && !(cal_done_i && st_q.busy) &&
                (st_q.rcnt == (st_q.rlen - 5'd1)))
            begin
                st_d.rdy_n = 1'b1;  // [RULE19]
            end
        end

        // New conversion word; set comes after clear so it wins
        if (conv_valid_i && !st_q.busy &&
            !is_cal(st_d.ctrl[`MODE_HI:`MODE_LO]))  // [RULE22]
        begin
            // Background mode keeps one word in six [RULE12]
            st_d.bgcnt = st_q.bgcnt + 3'd1;
            if ((mode != `MODE_BG_CAL) ||
                (st_q.bgcnt == (`BG_DIV - 3'd1)))
            begin
                st_d.bgcnt = '0;
                st_d.dreg  = conv_data_i;  // [RULE7]
                st_d.rdy_n = 1'b0;  // [RULE19]
            end
        end
    end

    // Master domain register
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            st_q       <= '0;
            st_q.wf_s1 <= 1'b1;
            st_q.wf_s2 <= 1'b1;
            st_q.rf_s1 <= 1'b1;
            st_q.rf_s2 <= 1'b1;
            st_q.rf_s3 <= 1'b1;
            st_q.ctrl  <= `CTRL_RESET;  // [RULE7] [RULE20]
            st_q.rlen  <= `WORD_BITS;
            st_q.oe_n  <= 1'b1;
            st_q.rdy_n <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Pins and configuration outputs from flip-flops; background flag decoded from mode
    assign serial_io_line_o            = st_q.sdo;
    assign serial_io_line_oe_n_o       = st_q.oe_n;
    assign result_ready_n_o            = st_q.rdy_n;
    assign cal_start_o                 = st_q.cal_start;
    assign cal_mode_o                  = mode;
    assign gain_o                      = st_q.ctrl[`GAIN_HI:`GAIN_LO];
    assign channel_o                   = chan;
    assign excitation_current_enable_o = st_q.ctrl[`EXC_BIT];
    assign burnout_current_enable_o    = st_q.ctrl[`BURN_BIT];
    assign unipolar_o                  = st_q.ctrl[`UNI_BIT];
    assign notch_code_o                = st_q.ctrl[`NOTCH_HI:`NOTCH_LO];
    assign background_cal_o            = (mode == `MODE_BG_CAL);

endmodule : adc_ctrl

// ---- hw/adc_ctrl_map.svh ----
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH

// Serial word length and short output word length
`define WORD_BITS      5'd24
`define SHORT_BITS     5'd16

// Control word field positions
`define MODE_HI        23
`define MODE_LO        21
`define GAIN_HI        20
`define GAIN_LO        18
`define CHAN_HI        17
`define CHAN_LO        16
`define WL_BIT         15
`define EXC_BIT        14
`define BURN_BIT       13
`define UNI_BIT        12
`define NOTCH_HI       11
`define NOTCH_LO       0

// Control word value after reset
`define CTRL_RESET     24'h000000

// Operating mode codes
`define MODE_NORMAL    3'h0
`define MODE_SELF_CAL  3'h1
`define MODE_SYS_ZERO  3'h2
`define MODE_SYS_FULL  3'h3
`define MODE_SYS_OFS   3'h4
`define MODE_BG_CAL    3'h5
`define MODE_ZS_COEF   3'h6
`define MODE_FS_COEF   3'h7

// Background calibration word rate divider
`define BG_DIV         3'd6

// Coefficient store: one entry per channel code
`define COEF_ENTRIES   4

`endif

// ---- hw/adc_ctrl_pkg.sv ----
package adc_ctrl_pkg;

`include "adc_ctrl_map.svh"

    // State of the master clock domain
    typedef struct packed {
        logic        wf_s1;     // Write frame sync stage 1
        logic        wf_s2;     // Write frame sync stage 2
        logic        rf_s1;     // Read frame sync stage 1
        logic        rf_s2;     // Read frame sync stage 2
        logic        rf_s3;     // Read frame, edge detect
        logic        rs_s1;     // Register select sync stage 1
        logic        rs_s2;     // Register select sync stage 2
        logic        wt_s1;     // Write bit toggle sync 1
        logic        wt_s2;     // Write bit toggle sync 2
        logic        wt_s3;     // Write bit toggle, edge detect
        logic        rt_s1;     // Read bit toggle sync 1
        logic        rt_s2;     // Read bit toggle sync 2
        logic        rt_s3;     // Read bit toggle, edge detect
        logic [23:0] ctrl;      // Control word
        logic [4:0]  wcnt;      // Bits seen in write frame
        logic [4:0]  rcnt;      // Bits sent in read frame
        logic [4:0]  rlen;      // Length of current read word
        logic [23:0] tx;        // Outgoing bits, MSB next
        logic        rdata;     // Current read is the data word
        logic        sdo;       // Serial line output bit
        logic        oe_n;      // Serial line drive enable, low
        logic [23:0] dreg;      // Conversion data word
        logic        rdy_n;     // Result ready, active low
        logic        busy;      // Calibration step running
        logic [2:0]  bgcnt;     // Background word rate divider
        logic        cal_start; // Calibration start pulse
    } main_st_t;

    // State of the serial clock domain
    typedef struct packed {
        logic        rst_s1;    // Reset sync stage 1
        logic        rst_s2;    // Reset sync stage 2
        logic [23:0] sh;        // Incoming shift register
        logic        wt;        // Toggles per written bit
        logic        rt;        // Toggles per read bit
    } link_st_t;

    // State of the coefficient store
    typedef struct packed {
        logic [`COEF_ENTRIES-1:0][47:0] ent; // {full, zero} per channel
        logic [23:0]                    rz;  // Registered zero read
        logic [23:0]                    rf;  // Registered full read
    } mem_st_t;

endpackage : adc_ctrl_pkg

// ---- hw/coef_mem.sv ----
`timescale 1ns/1ps
module coef_mem
    import adc_ctrl_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire logic [1:0]  wr_addr_i,
    input  wire logic        wr_zero_i,
    input  wire logic        wr_full_i,
    input  wire logic [23:0] wr_zero_data_i,
    input  wire logic [23:0] wr_full_data_i,
    input  wire logic [1:0]  rd_addr_i,
    output logic      [23:0] rd_zero_o,
    output logic      [23:0] rd_full_o
);

    mem_st_t st_q;  // Registered store
    mem_st_t st_d;  // Next store

    // Write halves by enable; read data registered one cycle later
    always_comb
    begin
        st_d = st_q;
        for (int i = 0; i < `COEF_ENTRIES; i++)
        begin
            // Each half of an entry has its own enable
            if (wr_zero_i && (wr_addr_i == 2'(i)))
            begin
                st_d.ent[i][23:0] = wr_zero_data_i;
            end
            if (wr_full_i && (wr_addr_i == 2'(i)))
            begin
                st_d.ent[i][47:24] = wr_full_data_i;
            end
        end
        // Old contents are read; a write reaches the read outputs two cycles later
        st_d.rz = st_q.ent[rd_addr_i][23:0];
        st_d.rf = st_q.ent[rd_addr_i][47:24];
    end

    // State register
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign rd_zero_o = st_q.rz;
    assign rd_full_o = st_q.rf;

endmodule : coef_mem

// ---- tb/adc_ctrl_checker.sv ----
`timescale 1ns/1ps
module adc_ctrl_checker
    import adc_ctrl_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire logic        read_frame_n_i,
    input  wire logic        conv_valid_i,
    input  wire logic        cal_done_i,
    input  wire logic        serial_io_line_oe_n_o,
    input  wire logic        result_ready_n_o,
    input  wire logic        cal_start_o,
    input  wire logic [2:0]  cal_mode_o,
    input  wire logic [2:0]  gain_o,
    input  wire logic [11:0] notch_code_o,
    input  wire logic        background_cal_o
);
    // All checks live in the master clock domain
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    chk_reset_idle: assert property (
        $fell(reset_i) |-> result_ready_n_o && serial_io_line_oe_n_o
        && cal_mode_o == 3'h0 && gain_o == 3'h0 && notch_code_o == 12'h0)
        else $error("outputs not idle after reset");
    chk_bg_first: assert property (
        $rose(background_cal_o) && result_ready_n_o
        |-> result_ready_n_o [*6])
        else $error("background word shown too early");
    chk_start_pulse: assert property (
        cal_start_o |=> !cal_start_o)
        else $error("calibration start longer than one cycle");
    chk_start_mode: assert property (
        cal_start_o |-> cal_mode_o inside {[3'h1:3'h4]})
        else $error("calibration start outside modes one to four");
    chk_start_ready: assert property (
        cal_start_o |-> result_ready_n_o ##1 result_ready_n_o)
        else $error("ready asserted as calibration starts");
    chk_cal_hold: assert property (
        cal_mode_o inside {[3'h1:3'h4]} && conv_valid_i && !cal_done_i
        |=> result_ready_n_o)
        else $error("conversion result shown during calibration");
    chk_cal_end: assert property (
        cal_mode_o inside {[3'h1:3'h4]} && $stable(cal_mode_o)
        && cal_done_i && !cal_start_o
        |=> cal_mode_o == 3'h0 && !result_ready_n_o)
        else $error("calibration end not reported");
    chk_ready_conv: assert property (
        conv_valid_i && cal_mode_o == 3'h0 |=> !result_ready_n_o)
        else $error("ready not low after new result");
    chk_oe_idle: assert property (
        read_frame_n_i [*5] |-> serial_io_line_oe_n_o)
        else $error("serial line driven outside read frame");

    // Main scenarios reached
    cover property (cal_start_o);
    cover property (background_cal_o && conv_valid_i);
    cover property (!serial_io_line_oe_n_o && !result_ready_n_o);
endmodule : adc_ctrl_checker

bind adc_ctrl adc_ctrl_checker chk (
    .mclk_i(mclk_i), .reset_i(reset_i), .read_frame_n_i(read_frame_n_i),
    .conv_valid_i(conv_valid_i), .cal_done_i(cal_done_i),
    .serial_io_line_oe_n_o(serial_io_line_oe_n_o),
    .result_ready_n_o(result_ready_n_o), .cal_start_o(cal_start_o),
    .cal_mode_o(cal_mode_o), .gain_o(gain_o),
    .notch_code_o(notch_code_o), .background_cal_o(background_cal_o)
);

// ---- tb/host_model.sv ----
`timescale 1ns/1ps
module host_model (
    output logic        sclk_o,
    output logic        write_frame_n_o,
    output logic        read_frame_n_o,
    output logic        select_o,
    output logic        data_o,
    output logic        drive_o,
    input  wire logic   line_i,
    output logic [23:0] rd_word_o,
    output logic        rd_ev_o
);
    // Clock parked low, frames idle high
    initial
    begin
        {sclk_o, select_o, data_o, drive_o, rd_ev_o} = 5'h00;
        {write_frame_n_o, read_frame_n_o} = 2'h3;
        rd_word_o = 24'h0;
    end

    // Free pulses around reset; the link reset needs them
    task automatic spin(input int n);
        repeat (n)
        begin
            #40 sclk_o = 1'b1;
            #40 sclk_o = 1'b0;
        end
    endtask : spin

    // One framed transfer, MSB first, clock runs only inside it
    task automatic xfer(input logic wr, input logic sel, input int n,
                        input logic [23:0] w);
        logic [23:0] r;
        r = 24'h0;
        select_o = sel;
        drive_o = wr;
        if (wr)
            write_frame_n_o = 1'b0;
        else
            read_frame_n_o = 1'b0;
        #80;
        for (int i = 0; i < n; i++)
        begin
            // Changes on the low phase, stable at the rise
            data_o = w[23 - (i % 24)];
            #40 r = {r[22:0], line_i};
            sclk_o = 1'b1;
            #40 sclk_o = 1'b0;
        end
        #40;
        {write_frame_n_o, read_frame_n_o} = 2'h3;
        drive_o = 1'b0;
        #200;
        if (!wr)
        begin
            rd_word_o = r;
            rd_ev_o = 1'b1;
            #1 rd_ev_o = 1'b0;
        end
    endtask : xfer
endmodule : host_model

// ---- tb/adc_control_and_calibration_modes_bench.sv ----
`timescale 1ns/1ps
module adc_control_and_calibration_modes_bench;
    logic        mclk_i = 1'b0; // Master clock
    logic        reset_i;       // Sync reset
    logic        conv_valid_i;  // Conversion strobe
    logic [23:0] conv_data_i;   // Conversion word
    logic        cal_done_i;    // Calibration end strobe
    logic [23:0] cal_zero_i;    // Zero coefficient
    logic [23:0] cal_full_i;    // Full coefficient
    wire         sclk, wf_n, rf_n, sel, h_dat, h_drv, rd_ev, sio;
    wire  [23:0] rd_word;
    wire         sdo, oe_n, rdy_n, start, bg, exc, burn, uni;
    wire  [2:0]  mode, gain;
    wire  [1:0]  chan;
    wire  [11:0] notch;
    logic        tog = 1'b0;    // Floating line pattern
    logic [23:0] exp_q[$];      // Expected read words
    logic [23:0] ez[4];         // Expected zero coefficients
    logic [23:0] ef[4];         // Expected full coefficients
    logic [23:0] w, d;
    int          seed, n_errors, total_checks, n_starts, s, m;

    always #2.5 mclk_i = ~mclk_i;
    // No pull on the line: undriven reads a moving pattern
    always @(posedge mclk_i) tog <= ~tog;
    assign sio = !oe_n ? sdo : (h_drv ? h_dat : tog);
    // Count start pulses, one per calibration write
    always @(posedge mclk_i)
        if (start === 1'b1)
            n_starts++;

    adc_ctrl dut (
        .mclk_i(mclk_i), .reset_i(reset_i), .sclk_i(sclk),
        .write_frame_n_i(wf_n), .read_frame_n_i(rf_n),
        .register_select_pin_i(sel), .serial_io_line_i(sio),
        .serial_io_line_o(sdo), .serial_io_line_oe_n_o(oe_n),
        .result_ready_n_o(rdy_n), .conv_valid_i(conv_valid_i),
        .conv_data_i(conv_data_i), .cal_done_i(cal_done_i),
        .cal_zero_i(cal_zero_i), .cal_full_i(cal_full_i),
        .cal_start_o(start), .cal_mode_o(mode), .gain_o(gain),
        .channel_o(chan), .excitation_current_enable_o(exc),
        .burnout_current_enable_o(burn), .unipolar_o(uni),
        .notch_code_o(notch), .background_cal_o(bg)
    );
    host_model host (
        .sclk_o(sclk), .write_frame_n_o(wf_n), .read_frame_n_o(rf_n),
        .select_o(sel), .data_o(h_dat), .drive_o(h_drv), .line_i(sio),
        .rd_word_o(rd_word), .rd_ev_o(rd_ev)
    );

    task automatic check(input string nm, input logic [23:0] seen,
                         input logic [23:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    // Read with its expected word noted first
    task automatic rd(input logic s_, input int n, input logic [23:0] e);
        exp_q.push_back(e);
        host.xfer(1'b0, s_, n, 24'h0);
    endtask : rd

    // One-cycle strobes, launched on the falling edge
    task automatic strobe(input logic cal, input logic [23:0] a,
                          input logic [23:0] b);
        @(negedge mclk_i);
        conv_valid_i = !cal;
        cal_done_i = cal;
        conv_data_i = a;
        cal_zero_i = a;
        cal_full_i = b;
        @(negedge mclk_i);
        conv_valid_i = 1'b0;
        cal_done_i = 1'b0;
        @(negedge mclk_i);
    endtask : strobe

    // Scoreboard: oldest note against each finished read
    always @(posedge rd_ev)
        if (exp_q.size() == 0)
            check("read count", 24'h1, 24'h0);
        else
            check("read word", rd_word, exp_q.pop_front());

    // Watchdog against a hung run
    initial
    begin
        repeat (100000) @(posedge mclk_i);
        n_errors++;
        test_done();
    end

    initial
    begin
        seed = 47553;
        reset_i = 1'b1;
        {conv_valid_i, cal_done_i} = 2'b00;
        {conv_data_i, cal_zero_i, cal_full_i} = 72'h0;
        ez = '{default: 24'h0};
        ef = '{default: 24'h0};
        host.spin(5);
        @(negedge mclk_i) reset_i = 1'b0;
        host.spin(4);
        check("ready", {23'h0, rdy_n}, 24'h1);
        rd(1'b0, 24, 24'h0);
        // Random fields, normal mode; then short and long writes
        repeat (3)
        begin
            w = $random(seed);
            w[23:21] = 3'h0;
            host.xfer(1'b1, 1'b0, 24, w);
            check("fields", {mode, gain, chan, w[15], exc, burn, uni,
                  notch}, w);
            rd(1'b0, 24, w);
            host.xfer(1'b1, 1'b0, 12, ~w);
            rd(1'b0, 24, w);
            w = {3'h0, 21'($random(seed))};
            host.xfer(1'b1, 1'b0, 30, w);
            rd(1'b0, 24, w);
        end
        // Data word length by width bit
        for (m = 0; m < 2; m++)
        begin
            host.xfer(1'b1, 1'b0, 24, {8'h0, m[0], 15'h0});
            d = $random(seed);
            strobe(1'b0, d, 24'h0);
            check("ready", {23'h0, rdy_n}, 24'h0);
            rd(1'b1, m ? 24 : 16, m ? d : {8'h0, d[23:8]});
            check("ready", {23'h0, rdy_n}, 24'h1);
        end
        // Background: only every sixth result shown
        host.xfer(1'b1, 1'b0, 24, {3'h5, 21'h0});
        check("bg", {23'h0, bg}, 24'h1);
        for (m = 1; m < 7; m++)
        begin
            d = $random(seed);
            strobe(1'b0, d, 24'h0);
            check("ready", {23'h0, rdy_n}, {23'h0, m < 6});
        end
        rd(1'b1, 16, {8'h0, d[23:8]});
        // Calibration modes one to four, one channel each
        for (m = 1; m < 5; m++)
        begin
            s = n_starts;
            host.xfer(1'b1, 1'b0, 24, {m[2:0], 3'h0, m[1:0], 16'h0});
            check("starts", 24'(n_starts - s), 24'h1);
            check("ready", {23'h0, rdy_n}, 24'h1);
            strobe(1'b0, 24'($random(seed)), 24'h0);
            check("ready", {23'h0, rdy_n}, 24'h1);
            w = $random(seed);
            d = $random(seed);
            strobe(1'b1, w, d);
            check("mode", {21'h0, mode}, 24'h0);
            check("ready", {23'h0, rdy_n}, 24'h0);
            if (m != 3)
                ez[m[1:0]] = w;
            if (m != 2)
                ef[m[1:0]] = d;
            host.xfer(1'b1, 1'b0, 24, {3'h6, 3'h0, m[1:0], 16'h0});
            rd(1'b1, 24, ez[m[1:0]]);
            host.xfer(1'b1, 1'b0, 24, {3'h7, 3'h0, m[1:0], 16'h0});
            rd(1'b1, 24, ef[m[1:0]]);
        end
        // Coefficient writes: full commits, short leaves it
        for (m = 6; m < 8; m++)
        begin
            host.xfer(1'b1, 1'b0, 24, {m[2:0], 5'h0, 16'h0});
            w = $random(seed);
            host.xfer(1'b1, 1'b1, 24, w);
            rd(1'b1, 24, w);
            host.xfer(1'b1, 1'b1, 12, ~w);
            rd(1'b1, 24, w);
        end
        @(negedge mclk_i);
        check("pending", 24'(exp_q.size()), 24'h0);
        test_done();
    end
endmodule : adc_control_and_calibration_modes_bench
